// [ipm_pkg.sv]
// constants for the interrupt priority and power mode controller
// assumes a 32-bit apb register port and one 200 MHz clock

package ipm_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ      = 200;  // i_clk rate
    localparam int unsigned OSC_PER_MC   = 12;   // clocks per machine cycle
    localparam int unsigned RST_MIN_MC   = 2;    // least reset hold, machine cycles
    localparam int unsigned WAKE_MC_DEF  = 6144; // wake reset pulse, machine cycles
    localparam int unsigned BUSRST_MC_DEF = 8192; // stretch that also resets the bus unit

    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  POWER_CONTROL_IDX   = 8'h87;
    localparam logic [7:0]  IP1_IDX    = 8'hF8;
    localparam logic [11:0] ADDR_POWER_CONTROL  = {2'b00, POWER_CONTROL_IDX, 2'b00};
    localparam logic [11:0] ADDR_IP1   = {2'b00, IP1_IDX, 2'b00};
    localparam logic [11:0] ADDR_CMD   = 12'h000; // bus unit command
    localparam logic [11:0] ADDR_STAT  = 12'h004; // block status

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned PC_SMOD = 7;
    localparam int unsigned PC_WLE  = 4;
    localparam int unsigned PC_PD   = 1;
    localparam int unsigned PC_IDL  = 0;
    localparam int unsigned CMD_SLEEP = 4;
    localparam int unsigned IEN_GLOBAL = 7;
    localparam int unsigned IEN_BUS    = 5;
    localparam logic [7:0]  POWER_CONTROL_RST = 8'h00;
    localparam logic [7:0]  IP1_RST  = 8'h00;

    // ------------------------------------------------------------
    // vectors and service order
    // ------------------------------------------------------------
    localparam int unsigned NSRC = 15;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [14:0] IDLE_LIVE = 15'h003F; // sources alive in idle
    localparam logic [3:0]  POLL_ORDER [NSRC] = '{4'h0, 4'h5, 4'hA, 4'h1, 4'h6,
        4'hB, 4'h2, 4'h7, 4'hC, 4'h3, 4'h8, 4'hD, 4'h4, 4'h9, 4'hE};

    // operating mode, gray along run -> idle -> power-down
    typedef enum logic [1:0] {
        MODE_RUN   = 2'b00,
        MODE_IDLE  = 2'b01,
        MODE_PDOWN = 2'b11
    } ipm_mode_e;

endpackage

// [ipm_ctrl.sv]
// interrupt arbitration and power modes behind an apb port
// assumes a core that acks vectors and signals return from service
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps

module ipm_ctrl #(
    parameter int unsigned WAKE_MC   = ipm_pkg::WAKE_MC_DEF,
    parameter int unsigned BUSRST_MC = ipm_pkg::BUSRST_MC_DEF
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic [31:0]      o_prdata,
    // interrupt sources, vector order
    input  wire logic [14:0] i_irq_request,
    input  wire logic [14:0] i_src_enable,
    input  wire logic [7:0]  i_first_irq_enable,
    input  wire logic [6:0]  i_base_level,
    // core handshake
    output logic             o_irq_valid,
    output logic [15:0]      o_irq_vector,
    input  wire logic        i_irq_ack,
    input  wire logic        i_reti,
    // watchdog
    input  wire logic        i_wdt_load,
    input  wire logic        i_wdt_overflow,
    input  wire logic        i_watchdog_enable_input_n,
    output logic             o_watchdog_load_enable,
    // reset pin, active high, driven high only during the wake pulse
    input  wire logic        i_rst_pin,
    output logic             o_rst_pin_out,
    output logic             o_rst_pin_oe,
    // bus unit
    input  wire logic        i_bus_receive_a,
    input  wire logic        i_bus_receive_b,
    input  wire logic        i_bus_tx_a,
    input  wire logic        i_bus_tx_b,
    output logic             o_bus_transmit_a,
    output logic             o_bus_transmit_b,
    output logic             o_bus_clk_en,
    output logic             o_bus_reset,
    // core side pins and controls
    input  wire logic        i_ale,
    input  wire logic        i_fetch,
    input  wire logic        i_pwm0,
    input  wire logic        i_pwm1,
    input  wire logic        i_ext_prog,
    output logic             o_ale,
    output logic             o_program_fetch_strobe,
    output logic             o_pwm0,
    output logic             o_pwm1,
    output logic             o_port0_float,
    output logic             o_port2_hold_addr,
    output logic             o_cpu_halt,
    output logic             o_osc_stop,
    output logic             o_t2_stop_reset,
    output logic             o_adc_abort,
    output logic             o_core_reset,
    output logic             o_smod
);
    import ipm_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [1:0]  sync1, sync2;     // reset pin, enable pin
    logic [1:0]  rx1, rx2;         // receive inputs
    logic [3:0]  div_cnt;          // machine cycle divider
    logic        mc_tick;          // one pulse per machine cycle
    logic        wake_go;          // bus wake starts this cycle
    logic [13:0] rst_cnt;          // machine cycles of pin high
    logic [13:0] wake_cnt;         // wake pulse remaining
    logic        wake_seen;        // current pin reset is our own
    logic        core_rst;         // internal reset, not bus unit
    logic        bus_rst;          // bus unit reset
    logic        smod, watchdog_load_enable, pd, idle_bit;
    logic [1:0]  gf;               // general flags
    logic [7:0]  ip1;              // timer2 priority levels
    logic        sleep;            // bus unit sleep bit
    logic        act_hi, act_lo;   // service in progress
    logic        irq_valid, win_hi;
    logic [3:0]  win_idx;
    ipm_mode_e   mode;

    // ------------------------------------------------------------
    // synchronisers and machine cycle enable
    // ------------------------------------------------------------
    // pins come from outside, two flops before any use
    always_ff @(posedge i_clk) begin
        sync1 <= {i_rst_pin, i_watchdog_enable_input_n};
        sync2 <= sync1;
        rx1   <= {i_bus_receive_b, i_bus_receive_a};
        rx2   <= rx1;
    end

    // divider, free running so reset timing holds in any mode;
    // restarts on a bus wake so the pulse spans whole machine cycles
    always_ff @(posedge i_clk) begin
        if (i_srst || wake_go) begin
            div_cnt <= 4'h0;
        end else if (div_cnt == 4'(OSC_PER_MC - 1)) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end
    assign mc_tick = (div_cnt == 4'(OSC_PER_MC - 1));

    logic pin_high, ew_ok, dominant, ge, bus_en;
    assign pin_high = sync2[1];
    assign ew_ok    = sync2[0];           // enable pin high
    assign dominant = ~(rx2[0] & rx2[1]); // dominant is low
    assign ge       = i_first_irq_enable[IEN_GLOBAL];
    assign bus_en   = i_first_irq_enable[IEN_BUS];

    // ------------------------------------------------------------
    // reset pin timing and wake pulse
    // ------------------------------------------------------------
    // counts held machine cycles, saturating at the bus reset limit
    always_ff @(posedge i_clk) begin
        if (i_srst || !pin_high) begin
            rst_cnt <= 14'h0000;
        end else if (mc_tick && rst_cnt < 14'(BUSRST_MC)) begin
            rst_cnt <= rst_cnt + 14'h0001;
        end
    end

    logic wake_act, hw_rst;
    assign wake_act = (wake_cnt != 14'h0000);
    assign wake_go  = pd && dominant && ge && bus_en && !wake_act;
    assign hw_rst   = (rst_cnt >= 14'(RST_MIN_MC));

    // wake pulse drives the pin high for its full width
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wake_cnt <= 14'h0000;
        end else if (wake_go) begin
            wake_cnt <= 14'(WAKE_MC);
        end else if (wake_act && mc_tick) begin
            wake_cnt <= wake_cnt - 14'h0001;
        end
    end

    // remembers that the pin reset was raised by our wake pulse
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wake_seen <= 1'b0;
        end else if (wake_go) begin
            wake_seen <= 1'b1;
        end else if (!wake_act && !pin_high) begin
            wake_seen <= 1'b0;
        end
    end

    // internal resets; wake keeps the bus unit unless stretched
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            core_rst <= 1'b0;
            bus_rst  <= 1'b0;
        end else begin
            core_rst <= hw_rst || wake_act || i_wdt_overflow;
            bus_rst  <= hw_rst && (!wake_seen || rst_cnt >= 14'(BUSRST_MC));
        end
    end

    // ------------------------------------------------------------
    // apb decode and read data
    // ------------------------------------------------------------
    logic sel_power_control, sel_ip1, sel_cmd, sel_stat, mapped, wr, acc;
    logic [7:0] rd_byte;

    // address decode, unmapped answers with an error
    always_comb begin
        sel_power_control = 1'b0;
        sel_ip1  = 1'b0;
        sel_cmd  = 1'b0;
        sel_stat = 1'b0;
        if (i_paddr == ADDR_POWER_CONTROL) begin
            sel_power_control = 1'b1;
        end else if (i_paddr == ADDR_IP1) begin
            sel_ip1 = 1'b1;
        end else if (i_paddr == ADDR_CMD) begin
            sel_cmd = 1'b1;
        end else if (i_paddr == ADDR_STAT) begin
            sel_stat = 1'b1;
        end
    end
    assign mapped = sel_power_control | sel_ip1 | sel_cmd | sel_stat;
    assign acc    = i_psel && i_penable;
    assign wr     = acc && i_pwrite;
    assign o_pready  = 1'b1;
    assign o_pslverr = acc && !mapped;

    // read byte, reserved bits read as zero
    always_comb begin
        rd_byte = 8'h00;
        if (sel_power_control) begin
            rd_byte = {smod, 2'b00, watchdog_load_enable, gf, pd, idle_bit};
        end else if (sel_ip1) begin
            rd_byte = ip1;
        end else if (sel_cmd) begin
            rd_byte = {3'b000, sleep, 4'h0};
        end else if (sel_stat) begin
            rd_byte = {act_hi, act_lo, irq_valid, wake_act, sleep, pd, idle_bit & ~pd, 1'b0};
        end
    end

    // read data caught in the setup phase, zero wait access
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable) begin
            o_prdata <= {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // power control register
    // ------------------------------------------------------------
    logic [14:0] pend;
    logic        idle_wake, wr_pc;
    assign pend      = i_irq_request & i_src_enable & {NSRC{ge}};
    assign wr_pc     = wr && sel_power_control;
    assign idle_wake = idle_bit && !pd && |(pend & IDLE_LIVE);

    // software write wins over a same-cycle watchdog load clear
    always_ff @(posedge i_clk) begin
        if (i_srst || core_rst) begin
            {smod, watchdog_load_enable, gf, pd, idle_bit} <= {POWER_CONTROL_RST[7], POWER_CONTROL_RST[4:0]};
        end else if (wr_pc) begin
            smod <= i_pwdata[PC_SMOD];
            watchdog_load_enable  <= i_pwdata[PC_WLE];
            gf   <= i_pwdata[3:2];
            pd   <= i_pwdata[PC_PD] && ew_ok;
            idle_bit  <= i_pwdata[PC_IDL];
        end else begin
            if (i_wdt_load) begin
                watchdog_load_enable <= 1'b0;
            end
            if (idle_wake) begin
                idle_bit <= 1'b0;
            end
        end
    end

    // priority byte, cleared with the core registers
    always_ff @(posedge i_clk) begin
        if (i_srst || core_rst) begin
            ip1 <= IP1_RST;
        end else if (wr && sel_ip1) begin
            ip1 <= i_pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // bus unit sleep bit
    // ------------------------------------------------------------
    // power-down entry forces sleep ahead of any wake or write
    always_ff @(posedge i_clk) begin
        if (i_srst || bus_rst) begin
            sleep <= 1'b0;
        end else if (wr_pc && i_pwdata[PC_PD] && ew_ok) begin
            sleep <= 1'b1;
        end else if (wr && sel_cmd) begin
            sleep <= i_pwdata[CMD_SLEEP];
        end else if (sleep && dominant) begin
            sleep <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // interrupt arbitration
    // ------------------------------------------------------------
    // first request met along the fixed poll order
    function automatic logic [4:0] pick_first(input logic [14:0] req);
        logic [4:0] r;
        r = 5'h00;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[POLL_ORDER[i]]) begin
                r = {1'b1, POLL_ORDER[i]};
            end
        end
        return r;
    endfunction

    logic [14:0] lvl;
    logic [4:0]  hi_pick, lo_pick;
    logic        take_hi, take_lo, acked, next_valid;
    // levels in vector order, sources 0 to 5 and 10 from the first level register
    assign lvl = {ip1[7:4], i_base_level[6], ip1[3:0], i_base_level[5:0]};
    assign hi_pick = pick_first(pend & lvl);
    assign lo_pick = pick_first(pend & ~lvl);
    assign take_hi = hi_pick[4] && !act_hi;
    assign take_lo = lo_pick[4] && !act_hi && !act_lo;
    assign acked   = i_irq_ack && irq_valid;
    // nothing offered while stopped or in reset; drop after ack
    assign next_valid = (take_hi || take_lo) && !pd && !core_rst && !acked;

    // offered vector, recomputed each cycle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            irq_valid    <= 1'b0;
            win_hi       <= 1'b0;
            win_idx      <= 4'h0;
            o_irq_vector <= VEC_BASE;
        end else begin
            irq_valid    <= next_valid;
            win_hi       <= take_hi;
            win_idx      <= take_hi ? hi_pick[3:0] : lo_pick[3:0];
            o_irq_vector <= VEC_BASE + {9'h000, take_hi ? hi_pick[3:0] : lo_pick[3:0], 3'b000};
        end
    end

    // service nesting; an ack in the same cycle as a return wins
    always_ff @(posedge i_clk) begin
        if (i_srst || core_rst) begin
            act_hi <= 1'b0;
            act_lo <= 1'b0;
        end else begin
            if (i_reti) begin
                if (act_hi) begin
                    act_hi <= 1'b0;
                end else begin
                    act_lo <= 1'b0;
                end
            end
            if (acked && win_hi) begin
                act_hi <= 1'b1;
            end else if (acked) begin
                act_lo <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // mode outputs
    // ------------------------------------------------------------
    always_comb begin
        if (pd) begin
            mode = MODE_PDOWN;
        end else if (idle_bit) begin
            mode = MODE_IDLE;
        end else begin
            mode = MODE_RUN;
        end
    end

    logic in_idle, in_pd;
    assign in_idle = (mode == MODE_IDLE);
    assign in_pd   = (mode == MODE_PDOWN);
    assign o_cpu_halt      = in_idle || in_pd;
    assign o_t2_stop_reset = in_idle;
    assign o_adc_abort     = in_idle;
    assign o_osc_stop      = in_pd;
    assign o_pwm0 = i_pwm0 || in_idle || in_pd;
    assign o_pwm1 = i_pwm1 || in_idle || in_pd;
    // strobes high in idle, low in power-down
    assign o_ale                  = !in_pd && (in_idle || i_ale);
    assign o_program_fetch_strobe = !in_pd && (in_idle || i_fetch);
    assign o_port0_float     = i_ext_prog && (in_idle || in_pd);
    assign o_port2_hold_addr = i_ext_prog && in_idle;
    // recessive level is high; the clock gate saves bus unit power
    assign o_bus_transmit_a = i_bus_tx_a || sleep || in_pd;
    assign o_bus_transmit_b = i_bus_tx_b || sleep || in_pd;
    assign o_bus_clk_en     = !sleep;
    assign o_rst_pin_out = 1'b1;
    assign o_rst_pin_oe  = wake_act;
    assign o_bus_reset   = bus_rst;
    assign o_core_reset  = core_rst;
    assign o_irq_valid   = irq_valid;
    assign o_watchdog_load_enable = watchdog_load_enable;
    assign o_smod = smod;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    pd_guard_a: assert property ($rose(pd) |-> $past(wr_pc && i_pwdata[PC_PD] && ew_ok))
        else $error("power-down set without enable pin");
    pd_wins_a: assert property (pd && idle_bit |-> o_osc_stop && !o_t2_stop_reset)
        else $error("idle not overridden by power-down");
    wle_clear_a: assert property (i_wdt_load && !wr_pc && !core_rst |=> !watchdog_load_enable)
        else $error("load enable not cleared on load");
    hi_first_a: assert property (irq_valid && $past(|(pend & lvl) && !act_hi) |-> win_hi)
        else $error("low request chosen over high");
    no_preempt_a: assert property (act_hi |-> !irq_valid)
        else $error("high service preempted");
    sleep_tx_a: assert property (sleep |-> o_bus_transmit_a && o_bus_transmit_b && !o_bus_clk_en)
        else $error("sleeping bus unit not recessive");
    pd_sleep_a: assert property ($rose(pd) |-> sleep && o_osc_stop)
        else $error("power-down without sleep bit");
    wake_len_a: assert property ($rose(wake_act) |-> wake_cnt == 14'(WAKE_MC) ##1 wake_act[*8])
        else $error("wake pulse wrong width");
    idle_exit_a: assert property (idle_wake && !wr_pc |=> !idle_bit)
        else $error("idle not ended by interrupt");
    vec_form_a: assert property (irq_valid |-> o_irq_vector[2:0] == 3'h3 && o_irq_vector <= 16'h0073)
        else $error("vector out of table");
    pd_pins_a: assert property (pd |-> !o_ale && !o_program_fetch_strobe && o_pwm0 && o_pwm1)
        else $error("power-down pin levels wrong");

endmodule // ipm_ctrl

// [ipm_core_model.sv]
// core stand-in: takes offered vectors and returns from service
// assumes the bench asks for every take and every return
`timescale 1ns/1ps

module ipm_core_model (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_srst,
    // block side
    input  wire logic i_irq_valid,
    output logic      o_irq_ack,
    output logic      o_reti,
    // bench commands
    input  wire logic i_take,
    input  wire logic i_done
);
    // ---------------------------------------------------------
    // handshake
    // ---------------------------------------------------------
    // one ack per offer; never acks an empty offer
    always_ff @(posedge i_clk) begin
        if (i_srst)
            o_irq_ack <= 1'b0;
        else
            o_irq_ack <= i_take & i_irq_valid & ~o_irq_ack;
    end
    // return follows the bench's request one cycle late
    always_ff @(posedge i_clk) begin
        if (i_srst)
            o_reti <= 1'b0;
        else
            o_reti <= i_done;
    end
endmodule // ipm_core_model

// [testbench.sv]
// bench for the priority and power mode block, with a core stand-in
// assumes short wake counts so the pulse fits a brief run
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end

module testbench;
    import ipm_pkg::*;
    // ---------------------------------------------------------
    // signals
    // ---------------------------------------------------------
    localparam int WAKE = 8;   // shortened wake pulse, machine cycles
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [14:0] req = 15'h0000;
    logic [15:0] irq_vector;
    logic pready, pslverr, irq_valid, ack, reti, err, take = 1'b0, done = 1'b0;
    logic wdt_load = 1'b0, wdt_ovf = 1'b0, ew = 1'b0, watchdog_load_enable, rst_ext = 1'b0, rst_out, rst_oe;
    logic rxa = 1'b1, rxb = 1'b1, txa = 1'b0, txb = 1'b0, otxa, otxb, clk_en, bus_rst;
    logic ale = 1'b0, fetch = 1'b0, pwm0 = 1'b0, pwm1 = 1'b0, ext_prog = 1'b0;
    logic oale, ofetch, opwm0, opwm1, p0f, p2h, halt, osc_stop, t2sr, adc_ab, core_rst, smod;
    logic [7:0] pv, ien = 8'hA0;
    int n_fail = 0, cmp_count = 0, seed = 63, cycles = 0, cnt;
    int order[$] = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14}; // expected service order

    ipm_ctrl #(.WAKE_MC(WAKE), .BUSRST_MC(16)) dut_u (.i_clk(clk), .i_srst(srst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_prdata(prdata), .i_irq_request(req), .i_src_enable(15'h7FFF),
        .i_first_irq_enable(ien), .i_base_level(7'h00), .o_irq_valid(irq_valid), .o_irq_vector(irq_vector),
        .i_irq_ack(ack), .i_reti(reti), .i_wdt_load(wdt_load), .i_wdt_overflow(wdt_ovf),
        .i_watchdog_enable_input_n(ew), .o_watchdog_load_enable(watchdog_load_enable), .i_rst_pin(rst_ext | (rst_oe & rst_out)),
        .o_rst_pin_out(rst_out), .o_rst_pin_oe(rst_oe), .i_bus_receive_a(rxa), .i_bus_receive_b(rxb),
        .i_bus_tx_a(txa), .i_bus_tx_b(txb), .o_bus_transmit_a(otxa), .o_bus_transmit_b(otxb),
        .o_bus_clk_en(clk_en), .o_bus_reset(bus_rst), .i_ale(ale), .i_fetch(fetch), .i_pwm0(pwm0),
        .i_pwm1(pwm1), .i_ext_prog(ext_prog), .o_ale(oale), .o_program_fetch_strobe(ofetch), .o_pwm0(opwm0),
        .o_pwm1(opwm1), .o_port0_float(p0f), .o_port2_hold_addr(p2h), .o_cpu_halt(halt),
        .o_osc_stop(osc_stop), .o_t2_stop_reset(t2sr), .o_adc_abort(adc_ab), .o_core_reset(core_rst),
        .o_smod(smod));
    ipm_core_model core_u (.i_clk(clk), .i_srst(srst), .i_irq_valid(irq_valid), .o_irq_ack(ack),
        .o_reti(reti), .i_take(take), .i_done(done));

    // ---------------------------------------------------------
    // clock, random pin traffic, timeout
    // ---------------------------------------------------------
    always #2.5 clk = ~clk;
    // random core pins so forced mode levels are really tested
    always @(posedge clk) begin
        cycles++;
        {ale, fetch, pwm0, pwm1, txa, txb} <= 6'($random(seed));
        if (cycles == 20000) begin
            n_fail++;
            wrap_up;
        end
    end

    task wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // apb cycle; answer taken only at the edge with pready high
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task rdchk(input string nm, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(nm, {24'h0, e}, rd)
    endtask
    // wait for an offer, compare the vector, have the core take it
    task offer(input logic [15:0] e);
        @(posedge clk);
        cnt = 0;
        while (irq_valid !== 1'b1 && cnt < 50) begin @(posedge clk); cnt++; end
        `CHK("vector", e, irq_vector)
        take <= 1'b1;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        take <= 1'b0;
    endtask
    task fin;
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        @(posedge clk);
    endtask

    // ---------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rdchk("power_control", ADDR_POWER_CONTROL, 8'h00);
        rdchk("prio", ADDR_IP1, 8'h00);
        apb(1'b0, 12'h7F0, 8'h00);
        `CHK("slverr", 1'b1, err)
        pv = 8'($random(seed));
        apb(1'b1, ADDR_IP1, pv);
        rdchk("prio", ADDR_IP1, pv);
        // all fifteen low at once: fixed order and vectors
        apb(1'b1, ADDR_IP1, 8'h00);
        req <= 15'h7FFF;
        foreach (order[k]) begin
            offer(16'(3 + 8 * order[k]));
            req[order[k]] <= 1'b0;
            fin;
        end
        // high beats low, high never preempted, low preempted by high
        apb(1'b1, ADDR_IP1, 8'h80);
        req <= 15'h4001;
        offer(16'h0073);
        req <= 15'h0001;
        repeat (20) @(posedge clk);
        `CHK("held", 1'b0, irq_valid)
        fin;
        offer(16'h0003);
        req <= 15'h4001;
        offer(16'h0073);
        req <= 15'h0000;
        fin;
        fin;
        apb(1'b1, ADDR_POWER_CONTROL, 8'h90);
        rdchk("wle", ADDR_POWER_CONTROL, 8'h90);
        `CHK("wle pin", 2'b11, {smod, watchdog_load_enable})
        wdt_load <= 1'b1;
        @(posedge clk) wdt_load <= 1'b0;
        rdchk("wle", ADDR_POWER_CONTROL, 8'h80);
        apb(1'b1, ADDR_CMD, 8'h10);
        #1 `CHK("sleep", 3'b011, {clk_en, otxa, otxb})
        rdchk("sleep", ADDR_CMD, 8'h10);
        @(posedge clk) rxb <= 1'b0;
        repeat (5) @(posedge clk);
        rxb <= 1'b1;
        rdchk("awake", ADDR_CMD, 8'h00);
        apb(1'b1, ADDR_POWER_CONTROL, 8'h02);
        rdchk("pd refused", ADDR_POWER_CONTROL, 8'h00);
        ext_prog <= 1'b1;
        apb(1'b1, ADDR_POWER_CONTROL, 8'h01);
        #1 `CHK("idle", 8'hFE, {halt, t2sr, adc_ab, oale, ofetch, opwm0 & opwm1, p0f & p2h, osc_stop})
        rdchk("idle", ADDR_POWER_CONTROL, 8'h01);
        @(posedge clk) req <= 15'h0002;
        repeat (3) @(posedge clk);
        rdchk("irq ends idle", ADDR_POWER_CONTROL, 8'h00);
        offer(16'h000B);
        req <= 15'h0000;
        fin;
        apb(1'b1, ADDR_POWER_CONTROL, 8'h01);
        rst_ext <= 1'b1;
        repeat (28) @(posedge clk);
        rst_ext <= 1'b0;
        repeat (4) @(posedge clk);
        rdchk("pin ends idle", ADDR_POWER_CONTROL, 8'h00);
        apb(1'b1, ADDR_POWER_CONTROL, 8'h01);
        wdt_ovf <= 1'b1;
        @(posedge clk) wdt_ovf <= 1'b0;
        @(posedge clk) `CHK("core reset", 1'b1, core_rst)
        rdchk("wdt ends idle", ADDR_POWER_CONTROL, 8'h00);
        ew <= 1'b1;
        apb(1'b1, ADDR_CMD, 8'h10);
        apb(1'b1, ADDR_POWER_CONTROL, 8'h03);
        #1 `CHK("pdown", 6'h23, {osc_stop, t2sr, oale, ofetch, opwm0 & opwm1, otxa & otxb})
        rdchk("pd sleep", ADDR_CMD, 8'h10);
        // no wake while the bus unit source is disabled
        ien <= 8'h80;
        @(posedge clk) rxa <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK("no wake", 1'b0, rst_oe)
        rxa <= 1'b1;
        repeat (4) @(posedge clk);
        ien <= 8'hA0;
        // bus wake: pulse width in clocks, bus unit kept
        @(posedge clk) rxa <= 1'b0;
        cnt = 0;
        while (rst_oe !== 1'b1 && cnt < 50) begin @(posedge clk); cnt++; end
        cnt = 0;
        while (rst_oe === 1'b1 && cnt < 1000) begin @(posedge clk); cnt++; end
        rxa <= 1'b1;
        `CHK("wake width", WAKE * 12, cnt)
        `CHK("bus kept", 1'b0, bus_rst)
        rdchk("power_control woken", ADDR_POWER_CONTROL, 8'h00);
        // capacitance stretches the pin past the bus reset limit
        apb(1'b1, ADDR_POWER_CONTROL, 8'h02);
        rxa <= 1'b0;
        rst_ext <= 1'b1;
        repeat (250) @(posedge clk);
        `CHK("bus reset", 1'b1, bus_rst)
        rst_ext <= 1'b0;
        rxa <= 1'b1;
        wrap_up;
    end
endmodule // testbench
